// ==== shared/slbmc_pkg.sv ====
// package: constants for the self-test and mode controller (host side)
package slbmc_pkg;
    // controller register indices on the software port
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_STATUS   = 4'h1;
    localparam logic [3:0] REG_ERRCNT   = 4'h2;
    localparam logic [3:0] REG_RUNLEN   = 4'h3;
    localparam logic [3:0] REG_MODE     = 4'h4;
    // control field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT  = 1;
    localparam int CTRL_CLKSEL_BIT = 2;
    localparam int CTRL_CLR_BIT   = 3;
    // status field positions
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_RESULT_BIT  = 1;
    localparam int ST_VALID_BIT   = 2;
    localparam int ST_RUNERR_BIT  = 3;
    // mode field positions (strap decode order)
    localparam int MODE_LF_BIT    = 0;
    localparam int MODE_RPT_BIT   = 1;
    localparam int MODE_BC_BIT    = 2;
    localparam int MODE_AUD_BIT   = 3;
    // reset value and error counter ceiling
    localparam logic [31:0] RUNLEN_RST = 32'h0000_0000;
    localparam logic [7:0]  ERRCNT_MAX = 8'hFF;
    // time for the far end to lock after the request, before sampling result
    localparam int CLK_MHZ        = 100;
    localparam int LOCK_WAIT_US   = 50;
    localparam int LOCK_WAIT_CYC  = LOCK_WAIT_US * CLK_MHZ;
    // cycles in DONE before the result pin is taken as the verdict
    localparam int RESULT_SETTLE_CYC = 4;
    // strap code: 3-bit mode index 0..7 in strap table order
    localparam logic [3:0] STRAP_TABLE [8] = '{
        4'h0, 4'h2, 4'hA, 4'h1, 4'h9, 4'h3, 4'hB, 4'h5};
    typedef enum logic [3:0] {
        SLBMC_IDLE = 4'b0001,
        SLBMC_LOCK = 4'b0010,
        SLBMC_RUN  = 4'b0100,
        SLBMC_DONE = 4'b1000
    } slbmc_state_e;
endpackage : slbmc_pkg

// ==== core/slbmc_sync.sv ====
// two-flop synchroniser for a single pin level
`timescale 1ns/1ns
`default_nettype none
module slbmc_sync (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic d_i,
    output var  logic q_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } slbmc_sync_s;
    slbmc_sync_s st_r;
    slbmc_sync_s st_nxt;
    always_comb begin
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q_o = st_r.s2;
endmodule : slbmc_sync
`default_nettype wire

// ==== core/slbmc_errcnt.sv ====
// saturating error pulse counter fed by falling edges of the result pin
`timescale 1ns/1ns
`default_nettype none
module slbmc_errcnt
    import slbmc_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         clr_i,
    input  wire logic         inc_i,
    output var  logic [W-1:0] cnt_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } slbmc_cnt_s;
    slbmc_cnt_s st_r;
    slbmc_cnt_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (clr_i) begin
            st_nxt.cnt = '0;
        end else if (inc_i && st_r.cnt != {W{1'b1}}) begin
            // saturate rather than wrap so a long faulty run never reads low
            st_nxt.cnt = st_r.cnt + W'(1);
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign cnt_o = st_r.cnt;
endmodule : slbmc_errcnt
`default_nettype wire

// ==== core/slbmc_ctrl.sv ====
// host controller: runs a link self test through the receiver pins
// How it works
// - host raises receiver self-test request pin, drives clock-select pin.
// - request travels over back channel while request pin stays high.
// - receiver raises result pin after lock; host waits then watches.
// - each errored payload pulses result low; host counts those pulses.
// - on request low, result pin holds final pass or fail.
// - final result held until new run, reset or power down.
// - host sets test length by holding request for programmed cycles.
// - after request drops both ends return to normal traffic.
// - receiver logs errors and drives switching pattern during test.
// - repeater tree: two levels max, three transmitters per receiver.
// - repeater nodes need unique addresses and repeater strap.
`timescale 1ns/1ns
`default_nettype none
module slbmc_ctrl
    import slbmc_pkg::*;
#(
    parameter int LOCK_WAIT = LOCK_WAIT_CYC,
    parameter int CNT_W     = 8
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output var  logic [31:0] rdata_o,
    input  wire logic [2:0]  strap_idx_i,
    input  wire logic        test_result_i,
    output var  logic        self_test_request_pin_o,
    output var  logic        self_test_clock_select_o,
    output var  logic        low_frequency_range_o,
    output var  logic        repeater_mode_o,
    output var  logic        backward_compat_o,
    output var  logic        secondary_audio_o
);
    slbmc_state_e        state_r;
    slbmc_state_e        state_nxt;

    typedef struct packed {
        logic [31:0] rdata;
        logic [31:0] runlen;
        logic [31:0] timer;
        logic        clksel;
        logic        req;
        logic        result;
        logic        valid;
        logic        runerr;
        logic        prev_res;
        logic        use_reg;
        logic [3:0]  mode_reg;
        logic [3:0]  mode;
        logic        strap_done;
    } slbmc_ctrl_s;
    slbmc_ctrl_s st_r;
    slbmc_ctrl_s st_nxt;

    logic             res_sync;
    logic [2:0]       strap_sync;
    logic             cnt_clr;
    logic             cnt_inc;
    logic [CNT_W-1:0] err_cnt;

    function automatic logic [3:0] strap_decode(input logic [2:0] idx);
        strap_decode = STRAP_TABLE[idx];
    endfunction : strap_decode

    slbmc_sync u_res_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (test_result_i),
        .q_o       (res_sync)
    );

    // strap pins come from outside the clock domain; they are static,
    // so one synchroniser per bit is enough
    slbmc_sync u_strap_sync0 (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (strap_idx_i[0]),
        .q_o       (strap_sync[0])
    );

    slbmc_sync u_strap_sync1 (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (strap_idx_i[1]),
        .q_o       (strap_sync[1])
    );

    slbmc_sync u_strap_sync2 (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (strap_idx_i[2]),
        .q_o       (strap_sync[2])
    );

    slbmc_errcnt #(
        .W (CNT_W)
    ) u_errcnt (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .clr_i     (cnt_clr),
        .inc_i     (cnt_inc),
        .cnt_o     (err_cnt)
    );

    logic start_cmd;
    logic stop_cmd;
    logic ctrl_wr;
    logic [3:0] strap_mode;

    always_comb begin
        ctrl_wr    = wr_i && addr_i == REG_CTRL;
        start_cmd  = ctrl_wr && wdata_i[CTRL_START_BIT];
        stop_cmd   = ctrl_wr && wdata_i[CTRL_STOP_BIT];
        strap_mode = strap_decode(strap_sync);
    end

    // counts each falling edge of the result pin while checking is live
    always_comb begin
        cnt_clr = ((state_r == SLBMC_IDLE || state_r == SLBMC_DONE)
                   && start_cmd && !st_r.mode[MODE_BC_BIT])
                  || (ctrl_wr && wdata_i[CTRL_CLR_BIT]);
        cnt_inc = state_r == SLBMC_RUN
                  && st_r.prev_res && !res_sync;
    end

    always_comb begin
        st_nxt          = st_r;
        state_nxt       = state_r;
        st_nxt.prev_res = res_sync;
        st_nxt.rdata    = 32'h0000_0000;

        // strap is caught in the first cycle after reset release, then followed while use_reg is clear
        if (!st_r.strap_done) begin
            st_nxt.mode       = strap_mode;
            st_nxt.strap_done = 1'b1;
        end
        if (wr_i && addr_i == REG_MODE) begin
            st_nxt.use_reg  = wdata_i[4];
            st_nxt.mode_reg = wdata_i[3:0];
        end
        if (st_r.strap_done) begin
            st_nxt.mode = st_r.use_reg ? st_r.mode_reg
                                       : strap_mode;
        end
        if (ctrl_wr) begin
            st_nxt.clksel = wdata_i[CTRL_CLKSEL_BIT];
        end
        if (wr_i && addr_i == REG_RUNLEN) begin
            st_nxt.runlen = wdata_i;
        end

        case (state_r)
            SLBMC_IDLE, SLBMC_DONE: begin
                if (start_cmd) begin
                    if (st_r.mode[MODE_BC_BIT]) begin
                        st_nxt.runerr = 1'b1;
                    end else begin
                        st_nxt.runerr = 1'b0;
                        st_nxt.req    = 1'b1;
                        st_nxt.valid  = 1'b0;
                        st_nxt.timer  = 32'(LOCK_WAIT);
                        state_nxt     = SLBMC_LOCK;
                    end
                end
            end
            SLBMC_LOCK: begin
                // far end needs time to wake and lock before result means much
                if (stop_cmd) begin
                    st_nxt.req   = 1'b0;
                    st_nxt.timer = 32'(RESULT_SETTLE_CYC);
                    state_nxt    = SLBMC_DONE;
                end else if (st_r.timer == 32'h0000_0000) begin
                    st_nxt.timer = st_r.runlen;
                    state_nxt    = SLBMC_RUN;
                end else begin
                    st_nxt.timer = st_r.timer - 32'h0000_0001;
                end
            end
            SLBMC_RUN: begin
                if (stop_cmd || (st_r.runlen != RUNLEN_RST
                                 && st_r.timer == 32'h0000_0000)) begin
                    st_nxt.req   = 1'b0;
                    st_nxt.timer = 32'(RESULT_SETTLE_CYC);
                    state_nxt    = SLBMC_DONE;
                end else if (st_r.timer != 32'h0000_0000) begin
                    st_nxt.timer = st_r.timer - 32'h0000_0001;
                end
            end
            default: begin
                st_nxt.req = 1'b0;
                state_nxt  = SLBMC_IDLE;
            end
        endcase

        // result pin level after request drop is the held verdict; the
        // receiver and the synchroniser both need a few cycles to settle
        if (state_r == SLBMC_DONE && !st_r.valid && !start_cmd) begin
            if (st_r.timer == 32'h0000_0000) begin
                st_nxt.result = res_sync;
                st_nxt.valid  = 1'b1;
            end else begin
                st_nxt.timer = st_r.timer - 32'h0000_0001;
            end
        end

        if (rd_i) begin
            case (addr_i)
                REG_CTRL:   st_nxt.rdata = {29'h0, st_r.clksel, 2'h0};
                REG_STATUS: st_nxt.rdata = {28'h0, st_r.runerr, st_r.valid,
                                            st_r.result,
                                            state_r != SLBMC_IDLE
                                            && state_r != SLBMC_DONE};
                REG_ERRCNT: st_nxt.rdata = {{(32-CNT_W){1'b0}}, err_cnt};
                REG_RUNLEN: st_nxt.rdata = st_r.runlen;
                REG_MODE:   st_nxt.rdata = {27'h0, st_r.use_reg, st_r.mode};
                default:    st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r    <= '0;
            state_r <= SLBMC_IDLE;
        end else begin
            st_r    <= st_nxt;
            state_r <= state_nxt;
        end
    end

    assign rdata_o                  = st_r.rdata;
    assign self_test_request_pin_o  = st_r.req;
    assign self_test_clock_select_o = st_r.clksel;
    assign low_frequency_range_o    = st_r.mode[MODE_LF_BIT];
    assign repeater_mode_o          = st_r.mode[MODE_RPT_BIT];
    assign backward_compat_o        = st_r.mode[MODE_BC_BIT];
    assign secondary_audio_o        = st_r.mode[MODE_AUD_BIT];
endmodule : slbmc_ctrl
`default_nettype wire

// ==== bench/slbmc_ctrl_chk.sv ====
// port assertions for the self-test controller
`timescale 1ns/1ns
`default_nettype none
module slbmc_ctrl_chk
    import slbmc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        self_test_request_pin_o,
    input wire logic        self_test_clock_select_o,
    input wire logic        low_frequency_range_o,
    input wire logic        repeater_mode_o,
    input wire logic        backward_compat_o,
    input wire logic        secondary_audio_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic       ctl = wr_i && addr_i == REG_CTRL;
    wire logic       req = self_test_request_pin_o;
    wire logic [3:0] mode_v = {secondary_audio_o, backward_compat_o,
                               repeater_mode_o, low_frequency_range_o};
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data not idle");
    a_unmapped_rd: assert property (rd_i && addr_i > REG_MODE
        |=> rdata_o == 32'h0) else $error("unmapped read not zero");
    a_start_req: assert property (ctl && wdata_i[0] && !wdata_i[1]
        && !backward_compat_o && !req |=> req) else $error("start ignored");
    a_bc_refuse: assert property (backward_compat_o && !req
        |=> !req) else $error("run in compatible mode");
    a_stop_drop: assert property (ctl && wdata_i[1] |=> !req)
        else $error("stop ignored");
    a_lock_hold: assert property ($rose(req) |-> req [*8])
        else $error("request dropped early");
    a_clksel_wr: assert property (ctl |=> self_test_clock_select_o
        == $past(wdata_i[CTRL_CLKSEL_BIT])) else $error("clock select wrong");
    a_mode_reg: assert property (wr_i && addr_i == REG_MODE
        && wdata_i[4] |-> ##2 mode_v == $past(wdata_i[3:0], 2))
        else $error("mode wrong");
endmodule : slbmc_ctrl_chk
`default_nettype wire

// ==== bench/slbmc_rx_model.sv ====
// behavioural receiver: self-test request in, result pin out
`timescale 1ns/1ns
`default_nettype none
module slbmc_rx_model (
    input  wire logic req_i,
    input  wire logic clksel_i,
    output var  logic result_o
);
    logic lclk = 1'b0;
    int   errs = 0;
    always #40 lclk = ~lclk;
    initial result_o = 1'b0;
    // lock takes time, so the pass level lags the request
    // the slower clock source takes a little longer to lock
    always @(posedge req_i) begin
        errs = 0;
        #(clksel_i ? 200 : 220);
        if (req_i) result_o = 1'b1;
    end
    always @(negedge req_i) result_o = (errs == 0);
    task automatic pulse_errors(input int k);
        repeat (k) begin
            @(posedge lclk) result_o = 1'b0;
            @(negedge lclk) result_o = 1'b1;
            errs++;
        end
    endtask : pulse_errors
endmodule : slbmc_rx_model
`default_nettype wire

// ==== bench/slbmc_ctrl_tb.sv ====
// bench for the self-test and mode controller
`timescale 1ns/1ns
`default_nettype none
module slbmc_ctrl_tb
    import slbmc_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [3:0]  addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        rd_d = 1'b0;
    logic [2:0]  strap_idx_i = 3'h0;
    logic [31:0] rdata_o;
    logic        req, csel, lf, rpt, bc, aud, res;
    logic [63:0] expq[$];
    logic [63:0] e;
    logic [3:0]  mv;
    logic [3:0]  tab [8] = '{4'h0, 4'h2, 4'hA, 4'h1, 4'h9, 4'h3, 4'hB, 4'h5};
    int          miscompares = 0, compares = 0, cyc = 0, seed = 71, n;
    always #5 clk_i = ~clk_i;
    slbmc_ctrl #(.LOCK_WAIT(8)) slbmc_ctrl_i (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .strap_idx_i(strap_idx_i), .test_result_i(res),
        .self_test_request_pin_o(req), .self_test_clock_select_o(csel),
        .low_frequency_range_o(lf), .repeater_mode_o(rpt),
        .backward_compat_o(bc), .secondary_audio_o(aud));
    slbmc_rx_model slbmc_rx_model_i (.req_i(req), .clksel_i(csel),
        .result_o(res));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    // mask lets a read check only the bits a scenario pins down
    task automatic rd(input logic [3:0] a, input logic [31:0] x,
                      input logic [31:0] m = 32'hFFFF_FFFF);
        addr_i <= a;
        rd_i <= 1'b1;
        expq.push_back({m, x});
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask : rd
    task automatic stop_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) begin
        if (rd_d) begin
            e = expq.pop_front();
            chk(rdata_o & e[63:32], e[31:0]);
        end
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 10000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(REG_STATUS, 32'h0);
        rd(4'h9, 32'h0);
        for (int i = 0; i < 8; i++) begin
            strap_idx_i <= 3'(i);
            repeat (4) @(posedge clk_i);
            chk({28'h0, aud, bc, rpt, lf}, {28'h0, tab[i]});
        end
        mv = 4'($random(seed));
        wr(REG_MODE, {27'h0, 1'b1, mv});
        @(posedge clk_i);
        chk({28'h0, aud, bc, rpt, lf}, {28'h0, mv});
        wr(REG_MODE, 32'h10);
        wr(REG_RUNLEN, 32'h14);
        wr(REG_CTRL, 32'h5);
        chk({31'h0, req}, 32'h1);
        chk({31'h0, csel}, 32'h1);
        repeat (40) @(posedge clk_i);
        chk({31'h0, req}, 32'h0);
        rd(REG_STATUS, 32'h6);
        rd(REG_ERRCNT, 32'h0);
        wr(REG_MODE, 32'h14);
        wr(REG_CTRL, 32'h1);
        chk({31'h0, req}, 32'h0);
        rd(REG_STATUS, 32'h8, 32'h9);
        wr(REG_MODE, 32'h10);
        wr(REG_RUNLEN, 32'h0);
        for (int k = 0; k < 2; k++) begin
            n = (k == 0) ? 300 : 1 + ($random(seed) & 7);
            wr(REG_CTRL, 32'h1);
            repeat (25) @(posedge clk_i);
            slbmc_rx_model_i.pulse_errors(n);
            @(posedge clk_i);
            wr(REG_CTRL, 32'h2);
            rd(REG_ERRCNT, (k == 0) ? 32'hFF : 32'(n));
        end
        // verdict is latched only after the result pin has settled
        repeat (8) @(posedge clk_i);
        rd(REG_STATUS, 32'h4, 32'h7);
        wr(REG_CTRL, 32'h8);
        rd(REG_ERRCNT, 32'h0);
        stop_test();
    end
endmodule : slbmc_ctrl_tb
bind slbmc_ctrl slbmc_ctrl_chk slbmc_ctrl_chk_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o),
    .self_test_request_pin_o(self_test_request_pin_o),
    .self_test_clock_select_o(self_test_clock_select_o),
    .low_frequency_range_o(low_frequency_range_o),
    .repeater_mode_o(repeater_mode_o), .backward_compat_o(backward_compat_o),
    .secondary_audio_o(secondary_audio_o));
`default_nettype wire
